//--- logic/sst_consts.vh
// Behaviour
// - one shared counter, per-strand nonprivileged-trap bit
// - shared counter advances every core clock
// - counter reads show low two bits zero
// - system counter aliases the cycle counter
// - match bits or bit 14 raise level-14
// - system match sets only bit 16
// - soft interrupt appears three cycles after set
// - clear register at trap pick gives 0x40
// - per-strand compares and soft interrupt registers
// - media writes skip graphics mask and scale
// - perf control 0x10, counter 0x11, per strand
// - nonprivileged perf control access: privileged-opcode
// - nonprivileged counter access with restrict: privileged-action
// - two trap levels, one trap state each
// - maximum global level is two
// - nonstandard float bit always reads zero
// - float version field always reads zero
// - float queue-not-empty always reads zero
// - per-strand processor, trap, global, float state
`ifndef SST_CONSTS_VH
`define SST_CONSTS_VH
// ancillary register numbers
`define SST_ASR_CYC     5'h04
`define SST_ASR_GFX     5'h13
`define SST_ASR_SSET    5'h14
`define SST_ASR_SCLR    5'h15
`define SST_ASR_SOFT    5'h16
`define SST_ASR_TCMP    5'h17
`define SST_ASR_SYSCYC  5'h18
`define SST_ASR_SCMP    5'h19
`define SST_ASR_PCTL    5'h10
`define SST_ASR_PCNT    5'h11
// privileged register numbers
`define SST_PR_TRAPST   5'h01
`define SST_PR_PROCST   5'h06
`define SST_PR_TDEPTH   5'h07
`define SST_PR_GDEPTH   5'h10
`define SST_PR_FLOAT    5'h1F
// field positions
`define SST_NPT_BIT     63
`define SST_CMP_DIS_BIT 63
`define SST_SOFT_CMATCH 0
`define SST_SOFT_L14    14
`define SST_SOFT_SMATCH 16
`define SST_PCTL_RESTR  0
`define SST_FLT_NONSTD  22
`define SST_FLT_QNE     13
`define SST_FLT_FIXED   64'h0000_0000_004E_2000
`define SST_GFX_KEEP    64'hFFFF_FFFF_0000_00F8
// limits and timing
`define SST_MAX_TDEPTH  2'h2
`define SST_MAX_GDEPTH  2'h2
`define SST_SOFT_DELAY  3
`define SST_TT_SOFT     8'h40
`endif

//--- logic/sst_delay_line.v
`timescale 1ns/1ps
// ****************************************
// fixed-depth delay for request levels
// ****************************************
module sst_delay_line #(
  parameter W = 8,
  parameter D = 3
) (
  // clock and reset
  input  wire         clk,
  input  wire         reset,
  // data
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage_r [0:D-1];
  integer     k;

  // each stage copies the previous; a short pulse still travels through
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (k = 0; k < D; k = k + 1) begin
        stage_r[k] <= {W{1'b0}};
      end
    end else begin
      stage_r[0] <= din;
      for (k = 1; k < D; k = k + 1) begin
        stage_r[k] <= stage_r[k-1];
      end
    end
  end

  assign dout = stage_r[D-1];
endmodule

//--- logic/sst_strand_regs.v
`timescale 1ns/1ps
`include "sst_consts.vh"
// ****************************************
// per-strand architectural state registers
// ****************************************
module sst_strand_regs (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // register access port
  input  wire        acc_valid,
  input  wire        acc_write,
  input  wire        acc_priv,
  input  wire        acc_space,
  input  wire [4:0]  acc_num,
  input  wire [1:0]  acc_strand,
  input  wire [63:0] acc_wdata,
  // access answer
  output reg         acc_done_r,
  output reg  [63:0] acc_rdata_r,
  output reg         exc_priv_opcode_r,
  output reg         exc_priv_action_r,
  output reg         exc_illegal_r,
  // media write of graphics status
  input  wire        gfx_media_we,
  input  wire [1:0]  gfx_media_strand,
  input  wire [63:0] gfx_media_data,
  // trap number choice
  input  wire        tt_req,
  input  wire [1:0]  tt_strand,
  output reg  [7:0]  tt_type_r,
  output reg         tt_valid_r,
  // interrupt requests per strand
  output wire [3:0]  l14_irq,
  output wire [3:0]  soft_irq
);
  // ****************************************
  // state
  // ****************************************
  reg  [62:0] cnt_r;
  reg  [3:0]  npt_r;
  reg  [63:0] tcmp_r [0:3];
  reg  [63:0] scmp_r [0:3];
  reg  [63:0] gfx_r  [0:3];
  reg  [63:0] pctl_r [0:3];
  reg  [63:0] pcnt_r [0:3];
  reg  [63:0] flt_r  [0:3];
  reg  [63:0] tst_r  [0:7];
  reg  [16:0] soft_r [0:3];
  reg  [12:0] pst_r  [0:3];
  reg  [1:0]  tdep_r [0:3];
  reg  [1:0]  gdep_r [0:3];
  reg  [67:0] soft_nxt;
  reg  [63:0] rmux;
  reg         sel_ok;
  reg         need_priv;
  reg         act_chk;
  wire        exc_opc;
  wire        exc_act;
  wire        go;
  wire        wr_go;
  wire [2:0]  tst_idx;
  wire [7:0]  irq_src;
  integer     i;
  integer     j;

  // highest pending level: match bits count as level 14
  function [3:0] top_level;
    input [16:0] v;
    integer n;
    begin
      top_level = 4'h0;
      for (n = 1; n < 16; n = n + 1) begin
        if (v[n]) begin
          top_level = n[3:0];
        end
      end
      if ((v[`SST_SOFT_CMATCH] | v[`SST_SOFT_SMATCH]) && (top_level < 4'hE)) begin
        top_level = 4'hE;
      end
    end
  endfunction

  // saturate a depth write at its maximum
  function [1:0] clamp2;
    input [63:0] v;
    input [1:0]  lim;
    begin
      clamp2 = (v > {62'h0, lim}) ? lim : v[1:0];
    end
  endfunction

  // trap state entry for current trap level of the accessing strand
  assign tst_idx = {acc_strand, 1'b0} + {2'b00, (tdep_r[acc_strand] == 2'h2)};

  // ****************************************
  // access decode and read mux
  // ****************************************
  always @* begin
    sel_ok    = 1'b1;
    need_priv = 1'b0;
    act_chk   = 1'b0;
    rmux      = 64'h0;
    if (!acc_space) begin
      case (acc_num)
        `SST_ASR_CYC, `SST_ASR_SYSCYC: begin
          // both names read the one counter, low bits hidden
          rmux      = {npt_r[acc_strand], cnt_r[62:2], 2'b00};
          need_priv = acc_write;
          act_chk   = npt_r[acc_strand];
        end
        `SST_ASR_GFX: rmux = gfx_r[acc_strand];
        `SST_ASR_SOFT: begin
          rmux      = {47'h0, soft_r[acc_strand]};
          need_priv = 1'b1;
        end
        `SST_ASR_SSET, `SST_ASR_SCLR: begin
          sel_ok    = acc_write;
          need_priv = 1'b1;
        end
        `SST_ASR_TCMP: begin
          rmux      = tcmp_r[acc_strand];
          need_priv = 1'b1;
        end
        `SST_ASR_SCMP: begin
          rmux      = scmp_r[acc_strand];
          need_priv = 1'b1;
        end
        `SST_ASR_PCTL: begin
          rmux      = pctl_r[acc_strand];
          need_priv = 1'b1;
        end
        `SST_ASR_PCNT: begin
          rmux    = pcnt_r[acc_strand];
          act_chk = pctl_r[acc_strand][`SST_PCTL_RESTR];
        end
        default: sel_ok = 1'b0;
      endcase
    end else begin
      case (acc_num)
        `SST_PR_TRAPST: begin
          // no trap state exists at trap level zero
          sel_ok    = (tdep_r[acc_strand] != 2'h0);
          rmux      = tst_r[tst_idx];
          need_priv = 1'b1;
        end
        `SST_PR_PROCST: begin
          rmux      = {51'h0, pst_r[acc_strand]};
          need_priv = 1'b1;
        end
        `SST_PR_TDEPTH: begin
          rmux      = {62'h0, tdep_r[acc_strand]};
          need_priv = 1'b1;
        end
        `SST_PR_GDEPTH: begin
          rmux      = {62'h0, gdep_r[acc_strand]};
          need_priv = 1'b1;
        end
        `SST_PR_FLOAT: rmux = flt_r[acc_strand] & ~`SST_FLT_FIXED;
        default: sel_ok = 1'b0;
      endcase
    end
  end

  // privilege faults take priority over completion
  assign exc_opc = acc_valid & sel_ok & need_priv & ~acc_priv;
  assign exc_act = acc_valid & sel_ok & act_chk & ~acc_priv & ~exc_opc;
  assign go      = acc_valid & sel_ok & ~exc_opc & ~exc_act;
  assign wr_go   = go & acc_write;

  // ****************************************
  // soft interrupt next state
  // ****************************************
  always @* begin
    soft_nxt = {soft_r[3], soft_r[2], soft_r[1], soft_r[0]};
    if (wr_go && !acc_space) begin
      case (acc_num)
        `SST_ASR_SOFT: soft_nxt[acc_strand*17 +: 17] = acc_wdata[16:0];
        `SST_ASR_SSET: soft_nxt[acc_strand*17 +: 17] = soft_r[acc_strand] | acc_wdata[16:0];
        `SST_ASR_SCLR: soft_nxt[acc_strand*17 +: 17] = soft_r[acc_strand] & ~acc_wdata[16:0];
        default: soft_nxt[acc_strand*17 +: 17] = soft_r[acc_strand];
      endcase
    end
    // compare matches come last so a set beats a clear in the same cycle
    for (j = 0; j < 4; j = j + 1) begin
      if (!tcmp_r[j][`SST_CMP_DIS_BIT] && (tcmp_r[j][62:0] == cnt_r)) begin
        soft_nxt[j*17 + `SST_SOFT_CMATCH] = 1'b1;
      end
      if (!scmp_r[j][`SST_CMP_DIS_BIT] && (scmp_r[j][62:0] == cnt_r)) begin
        soft_nxt[j*17 + `SST_SOFT_SMATCH] = 1'b1;
      end
    end
  end

  // ****************************************
  // shared counter
  // ****************************************
  // one counter for the core; a write through either name lands here
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 63'h0;
      npt_r <= 4'h0;
    end else if (wr_go && !acc_space &&
                 ((acc_num == `SST_ASR_CYC) || (acc_num == `SST_ASR_SYSCYC))) begin
      cnt_r             <= acc_wdata[62:0];
      npt_r[acc_strand] <= acc_wdata[`SST_NPT_BIT];
    end else begin
      cnt_r <= cnt_r + 63'h1;
    end
  end

  // ****************************************
  // per-strand registers
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < 4; i = i + 1) begin
        tcmp_r[i] <= 64'h8000_0000_0000_0000;
        scmp_r[i] <= 64'h8000_0000_0000_0000;
        gfx_r[i]  <= 64'h0;
        pctl_r[i] <= 64'h0;
        pcnt_r[i] <= 64'h0;
        flt_r[i]  <= 64'h0;
        soft_r[i] <= 17'h0;
        pst_r[i]  <= 13'h0;
        tdep_r[i] <= 2'h0;
        gdep_r[i] <= 2'h0;
      end
      for (i = 0; i < 8; i = i + 1) begin
        tst_r[i] <= 64'h0;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        soft_r[i] <= soft_nxt[i*17 +: 17];
      end
      // media path leaves mask and scale alone
      if (gfx_media_we) begin
        gfx_r[gfx_media_strand] <= (gfx_r[gfx_media_strand] & `SST_GFX_KEEP) |
                                   (gfx_media_data & ~`SST_GFX_KEEP);
      end
      if (wr_go && !acc_space) begin
        case (acc_num)
          `SST_ASR_GFX:  gfx_r[acc_strand]  <= acc_wdata;
          `SST_ASR_TCMP: tcmp_r[acc_strand] <= acc_wdata;
          `SST_ASR_SCMP: scmp_r[acc_strand] <= acc_wdata;
          `SST_ASR_PCTL: pctl_r[acc_strand] <= acc_wdata;
          `SST_ASR_PCNT: pcnt_r[acc_strand] <= acc_wdata;
          default: ;
        endcase
      end
      if (wr_go && acc_space) begin
        case (acc_num)
          `SST_PR_TRAPST: tst_r[tst_idx]     <= acc_wdata;
          `SST_PR_PROCST: pst_r[acc_strand]  <= acc_wdata[12:0];
          `SST_PR_TDEPTH: tdep_r[acc_strand] <= clamp2(acc_wdata, `SST_MAX_TDEPTH);
          `SST_PR_GDEPTH: gdep_r[acc_strand] <= clamp2(acc_wdata, `SST_MAX_GDEPTH);
          `SST_PR_FLOAT:  flt_r[acc_strand]  <= acc_wdata & ~`SST_FLT_FIXED;
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // access answer, one cycle after the request
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_done_r        <= 1'b0;
      acc_rdata_r       <= 64'h0;
      exc_priv_opcode_r <= 1'b0;
      exc_priv_action_r <= 1'b0;
      exc_illegal_r     <= 1'b0;
    end else begin
      acc_done_r        <= go;
      acc_rdata_r       <= (go && !acc_write) ? rmux : 64'h0;
      exc_priv_opcode_r <= exc_opc;
      exc_priv_action_r <= exc_act;
      exc_illegal_r     <= acc_valid & ~sel_ok;
    end
  end

  // ****************************************
  // trap number choice
  // ****************************************
  // the register is read again at pick time; an empty one still gives a trap
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tt_type_r  <= 8'h00;
      tt_valid_r <= 1'b0;
    end else begin
      tt_valid_r <= tt_req;
      if (tt_req) begin
        tt_type_r <= `SST_TT_SOFT + {4'h0, top_level(soft_r[tt_strand])};
      end
    end
  end

  // ****************************************
  // interrupt request levels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_src
      // any of the three level-14 sources keeps the request up
      assign irq_src[g]   = soft_r[g][`SST_SOFT_CMATCH] | soft_r[g][`SST_SOFT_L14] |
                            soft_r[g][`SST_SOFT_SMATCH];
      assign irq_src[g+4] = |soft_r[g];
    end
  endgenerate

  // a fixed delay models the pipe; a bit cleared early still fires
  sst_delay_line #(
    .W (8),
    .D (`SST_SOFT_DELAY)
  ) u_delay (
    .clk   (clk),
    .reset (reset),
    .din   (irq_src),
    .dout  ({soft_irq, l14_irq})
  );
endmodule

//--- test/sst_checker_sva.sv
`timescale 1ns/1ps
`include "sst_consts.vh"
// ****************
// access checker
// ****************
module sst_checker (
  // clock and reset
  input wire        clk,
  input wire        reset,
  // request
  input wire        acc_valid,
  input wire        acc_write,
  input wire        acc_priv,
  input wire        acc_space,
  input wire [4:0]  acc_num,
  input wire [1:0]  acc_strand,
  input wire [63:0] acc_wdata,
  // answer
  input wire        acc_done_r,
  input wire [63:0] acc_rdata_r,
  input wire        exc_priv_opcode_r,
  input wire        exc_priv_action_r,
  input wire        exc_illegal_r,
  // traps and interrupts
  input wire        tt_req,
  input wire        tt_valid_r,
  input wire [7:0]  tt_type_r,
  input wire [3:0]  l14_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // answer code: done, opcode, action, illegal
  wire [3:0] ans = {acc_done_r, exc_priv_opcode_r, exc_priv_action_r, exc_illegal_r};
  wire       rd  = acc_valid & ~acc_write;
  sequence s_pctl;
    acc_valid && !acc_space && acc_num == `SST_ASR_PCTL;
  endsequence
  // strand 0 only: keeps the index free of a local variable
  sequence s_soft_set;
    acc_valid && acc_write && acc_priv && !acc_space && acc_num == `SST_ASR_SOFT
      && acc_wdata[`SST_SOFT_L14] && acc_strand == 2'h0;
  endsequence
  a_one_answer: assert property (acc_valid |=> $onehot(ans))
    else $error("access without exactly one answer");
  a_no_answer: assert property (!acc_valid |=> ans == 4'h0)
    else $error("answer without access");
  a_ctl_user: assert property (!acc_priv ##0 s_pctl |=> exc_priv_opcode_r)
    else $error("user perf control access completed");
  a_ctl_priv: assert property (acc_priv ##0 s_pctl |=> acc_done_r)
    else $error("privileged perf control access refused");
  a_count_low: assert property (rd && !acc_space && (acc_num == `SST_ASR_CYC
    || acc_num == `SST_ASR_SYSCYC) |=> acc_rdata_r[1:0] == 2'h0)
    else $error("counter low bits not zero");
  a_float_fixed: assert property (rd && acc_space && acc_num == `SST_PR_FLOAT
    |=> (acc_rdata_r & `SST_FLT_FIXED) == 64'h0)
    else $error("float fixed bits not zero");
  a_tt_answer: assert property (tt_req |=> tt_valid_r && tt_type_r[7:4] == 4'h4)
    else $error("trap pick answer wrong");
  a_soft_late: assert property (s_soft_set |-> ##[3:4] l14_irq[0])
    else $error("level 14 request late");
endmodule

//--- test/strand_state_registers_bench.sv
`timescale 1ns/1ps
`include "sst_consts.vh"
`define CHK(nm, e, g) \
  n_tests++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); \
  end
module strand_state_registers_bench;
  // ********
  // stimulus
  // ********
  reg        clk, reset, acc_valid, acc_write, acc_priv, acc_space;
  reg        gfx_media_we, tt_req;
  reg [4:0]  acc_num;
  reg [1:0]  acc_strand, gfx_media_strand, tt_strand;
  reg [63:0] acc_wdata, gfx_media_data, rd_v, t0;
  reg [3:0]  ans;
  wire       acc_done_r, exc_priv_opcode_r, exc_priv_action_r, exc_illegal_r, tt_valid_r;
  wire [63:0] acc_rdata_r;
  wire [7:0] tt_type_r;
  wire [3:0] l14_irq, soft_irq;
  int        mismatches = 0;
  int        n_tests = 0;
  sst_strand_regs dut_u (.*);
  always #10 clk = ~clk;
  // one access: request held over exactly one taking edge
  task acc(input w, p, sp, input [4:0] n, input [1:0] s, input [63:0] d);
    @(posedge clk);
    #1 {acc_valid, acc_write, acc_priv, acc_space} = {1'b1, w, p, sp};
    {acc_num, acc_strand, acc_wdata} = {n, s, d};
    @(posedge clk);
    #1 acc_valid = 0;
    ans = {acc_done_r, exc_priv_opcode_r, exc_priv_action_r, exc_illegal_r};
    rd_v = acc_rdata_r;
  endtask
  task pick(input [1:0] s);
    @(posedge clk);
    #1 tt_req = 1;
    tt_strand = s;
    @(posedge clk);
    #1 tt_req = 0;
  endtask
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    {clk, reset, acc_valid, acc_write, acc_priv, acc_space, gfx_media_we, tt_req} = 8'h40;
    {acc_num, acc_strand, gfx_media_strand, tt_strand, acc_wdata, gfx_media_data} = 0;
    repeat (6) @(posedge clk);
    #1 reset = 0;
    acc(1, 1, 0, `SST_ASR_PCTL, 0, 64'h1);
    `CHK("perf ctl write", 4'h8, ans)
    acc(0, 0, 0, `SST_ASR_PCTL, 0, 0);
    `CHK("perf ctl user", 4'h4, ans)
    acc(0, 0, 0, `SST_ASR_PCNT, 0, 0);
    `CHK("perf cnt restricted", 4'h2, ans)
    acc(1, 0, 0, `SST_ASR_PCNT, 1, 64'h1234);
    acc(0, 0, 0, `SST_ASR_PCNT, 1, 0);
    `CHK("perf cnt user read", 64'h1234, rd_v)
    acc(0, 1, 0, `SST_ASR_PCNT, 0, 0);
    `CHK("perf cnt per strand", 64'h0, rd_v)
    $display("test perf done");
    acc(1, 1, 0, `SST_ASR_CYC, 0, 64'h100);
    acc(0, 1, 0, `SST_ASR_SYSCYC, 0, 0);
    `CHK("alias read", 64'h100, rd_v)
    t0 = rd_v;
    repeat (14) @(posedge clk);
    acc(0, 1, 0, `SST_ASR_SYSCYC, 0, 0);
    `CHK("count step", t0 + 64'h10, rd_v)
    `CHK("low bits", 2'h0, rd_v[1:0])
    acc(1, 1, 0, `SST_ASR_SYSCYC, 1, 64'h8000_0000_0000_0200);
    acc(0, 0, 0, `SST_ASR_CYC, 1, 0);
    `CHK("user trap bit", 4'h2, ans)
    acc(0, 0, 0, `SST_ASR_CYC, 0, 0);
    `CHK("shared count", 64'h200, rd_v & ~64'hFF)
    $display("test counter done");
    acc(1, 1, 0, `SST_ASR_SOFT, 0, 64'h4000);
    `CHK("l14 not early", 1'b0, l14_irq[0])
    repeat (4) @(posedge clk);
    #1 `CHK("l14 raised", 1'b1, l14_irq[0])
    pick(0);
    `CHK("pick l14", 8'h4E, tt_type_r)
    acc(1, 1, 0, `SST_ASR_SCLR, 0, 64'h4000);
    repeat (5) @(posedge clk);
    #1 `CHK("l14 drops", 4'h0, l14_irq)
    acc(1, 1, 0, `SST_ASR_SSET, 0, 64'h20);
    repeat (5) @(posedge clk);
    #1 `CHK("level 5 only", 2'b10, {soft_irq[0], l14_irq[0]})
    acc(1, 1, 0, `SST_ASR_SCLR, 0, 64'h20);
    pick(0);
    `CHK("pick empty", `SST_TT_SOFT, tt_type_r)
    acc(1, 1, 0, `SST_ASR_CYC, 0, 0);
    acc(1, 1, 0, `SST_ASR_SCMP, 2, 64'h40);
    repeat (80) @(posedge clk);
    acc(0, 1, 0, `SST_ASR_SOFT, 2, 0);
    `CHK("system match", 64'h1_0000, rd_v)
    `CHK("l14 from match", 4'h4, l14_irq)
    acc(0, 1, 0, `SST_ASR_SOFT, 3, 0);
    `CHK("soft per strand", 64'h0, rd_v)
    $display("test interrupt done");
    acc(1, 1, 1, `SST_PR_FLOAT, 3, {64{1'b1}});
    acc(0, 1, 1, `SST_PR_FLOAT, 3, 0);
    `CHK("float nonstandard", 1'b0, rd_v[`SST_FLT_NONSTD])
    `CHK("float ver", 3'h0, rd_v[19:17])
    `CHK("float queue", 1'b0, rd_v[`SST_FLT_QNE])
    acc(0, 1, 1, `SST_PR_FLOAT, 0, 0);
    `CHK("float per strand", 64'h0, rd_v)
    acc(1, 1, 1, `SST_PR_TDEPTH, 0, 64'h3);
    acc(0, 1, 1, `SST_PR_TDEPTH, 0, 0);
    `CHK("trap depth max", 64'h2, rd_v)
    acc(1, 1, 1, `SST_PR_GDEPTH, 0, 64'h3);
    acc(0, 1, 1, `SST_PR_GDEPTH, 0, 0);
    `CHK("global depth max", 64'h2, rd_v)
    acc(0, 1, 0, 5'h1E, 0, 0);
    `CHK("unmapped", 4'h1, ans)
    @(posedge clk);
    #1 gfx_media_we = 1;
    gfx_media_data = {64{1'b1}};
    @(posedge clk);
    #1 gfx_media_we = 0;
    acc(0, 1, 0, `SST_ASR_GFX, 0, 0);
    `CHK("media keep", ~`SST_GFX_KEEP, rd_v)
    $display("test state done");
    wrap_up;
  end
endmodule
bind sst_strand_regs sst_checker chk_u (.*);
